// File: hw/swim_status_unit.sv
`timescale 1ns/100ps
// How it works
// - 16-bit status word; bits 7, 9 read zero
// - Misaligned storage address sets bit 0
// - Address beyond storage size sets bit 1
// - Privileged instruction in problem state sets bit 2
// - Store to read-only segment in problem state, translator on, sets bit 3
// - Invalid opcode/function sets bit 4, program check
// - Absent-feature instruction sets bit 4, soft trap
// - Floating-point error sets bit 5
// - Stack overflow or underflow sets bit 6
// - Storage parity error sets bit 8
// - Control or channel failure resets the channel
// - Bit 12 tracks the last I/O sequence
// - Bit 13 marks an automatic program load
// - Enable and disable steer translator bit 14
// - Power/thermal warning sets bit 15, masked
// - Summary mask gates priority and warning interrupts
// - Summary mask cleared by call, disable, class
// - Summary mask set by enable, load, accept
// - While waiting, last active level's mask rules
// - Four-bit level mask, set and copied
// - Level mask forced to ones on resets
module swim_status_unit
	import swim_pkg::*;
(
	// Clock and reset.
	input  wire logic              clock,
	input  wire logic              reset,
	// Execution, instruction and load events.
	input  wire swim_exec_s        exec_ev,
	input  wire swim_instr_s       instr_ev,
	input  wire swim_load_s        load_ev,
	input  wire logic              auto_mode,
	input  wire logic              supervisor,
	input  wire logic [1:0]        active_level,
	input  wire logic              waiting,
	// Power and thermal warning pin.
	input  wire logic              power_warn_pin,
	// Priority requests from the channel.
	input  wire logic [3:0]        dev_req,
	input  wire logic [3:0]        dev_mask,
	// Class interrupt requests.
	output logic                   machine_check_q,
	output logic                   program_check_q,
	output logic                   soft_trap_q,
	output logic                   power_int_q,
	// Priority accept and channel reset.
	output logic [3:0]             prio_grant_q,
	output logic                   chan_reset_q,
	// Register read-back.
	output logic [15:0]            status_copy_q,
	output logic                   status_copy_valid_q,
	output logic [3:0]             level_mask_copy_q,
	output logic                   summary_q
);

	////////////////////////////////////////////////////////////////////
	logic [15:0] psw_q;
	logic [15:0] psw_d;
	logic [15:0] set_bits;
	logic [15:0] clr_bits;
	logic        inv_soft_q;
	logic [3:0]  lmask_q;
	logic [3:0]  summ_q;
	logic [1:0]  last_level_q;
	logic [2:0]  pw_sync_q;
	logic        pw_level_q;

	// Power pin passes three stages; a change counts once two agree.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			pw_sync_q  <= 3'h0;
			pw_level_q <= 1'b0;
		end else begin
			pw_sync_q <= {pw_sync_q[1:0], power_warn_pin};
			if (pw_sync_q[2] == pw_sync_q[1]) begin
				pw_level_q <= pw_sync_q[2];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Invalid-function decode; only the fixed-width entries are kept.
	wire [3:0] fn = exec_ev.func[3:0];
	wire       op_all_bad = exec_ev.opcode == OP_BAD_A ||
		exec_ev.opcode == OP_BAD_B || exec_ev.opcode == OP_BAD_C;
	wire       op08_bad = exec_ev.opcode == OP_08 &&
		fn[3] == 1'b0 && fn[1:0] != 2'h0;
	wire       op0b_bad = exec_ev.opcode == OP_0B &&
		(fn == 4'h5 || fn == 4'h7);
	wire       op1d_bad = exec_ev.opcode == OP_1D && fn[3:2] == 2'h3;
	wire       inv_prog = exec_ev.decode_valid &&
		(op_all_bad || op08_bad || op0b_bad || op1d_bad);
	wire       inv_soft = exec_ev.decode_valid &&
		(exec_ev.opcode == OP_ABSENT ||
		(exec_ev.opcode == OP_0B && supervisor &&
		fn[2:0] == 3'h3));

	wire proc_reset = load_ev.sys_reset || load_ev.initial_program_load;
	wire dis_xlat   = instr_ev.dis && instr_ev.word[WB_XLAT];
	wire en_xclr    = instr_ev.en && instr_ev.word[WB_XCLR];
	wire en_xset    = instr_ev.en && !instr_ev.word[WB_XCLR] &&
		instr_ev.word[WB_XLAT];
	wire clr_auto   = load_ev.load_key || load_ev.host_load ||
		(load_ev.initial_program_load && !auto_mode && !load_ev.auto_ipl);

	// Hardware events that set status bits.
	always_comb begin
		set_bits = SW_RESET;
		set_bits[BIT_SPEC]   = exec_ev.align_err;
		set_bits[BIT_RANGE]  = exec_ev.range_err;
		set_bits[BIT_PRIV]   = exec_ev.priv_instr && !supervisor;
		set_bits[BIT_PROT]   = exec_ev.store_ro_seg && !supervisor &&
			psw_q[BIT_XLATE];
		set_bits[BIT_INVF]   = inv_prog || inv_soft;
		set_bits[BIT_FLOAT]  = exec_ev.float_err;
		set_bits[BIT_STACK]  = exec_ev.stack_err;
		set_bits[BIT_PARITY] = exec_ev.parity_err;
		set_bits[BIT_CTRL]   = exec_ev.ctrl_fail;
		set_bits[BIT_IOCHK]  = exec_ev.chan_fail;
		set_bits[BIT_SEQ]    = instr_ev.io_cs_accept;
		set_bits[BIT_AUTO]   = load_ev.auto_ipl;
		set_bits[BIT_XLATE]  = en_xset && !proc_reset;
		set_bits[BIT_POWER]  = pw_level_q;
	end

	// Clears; error bits drop after a copy, status flags on their own.
	always_comb begin
		clr_bits = instr_ev.copy_status ? ERR_MASK : SW_RESET;
		clr_bits[BIT_SEQ]   = instr_ev.io_op && !instr_ev.io_cs_accept;
		clr_bits[BIT_AUTO]  = clr_auto;
		clr_bits[BIT_XLATE] = dis_xlat || en_xclr || proc_reset;
	end

	// Set beats clear so an event in the clearing cycle is kept.
	assign psw_d = ((psw_q & ~clr_bits) | set_bits) & ~RSV_MASK;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			psw_q      <= SW_RESET;
			inv_soft_q <= 1'b0;
		end else begin
			psw_q <= psw_d;
			if (set_bits[BIT_INVF]) begin
				inv_soft_q <= inv_soft && !inv_prog;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Level mask register; all levels enabled by any reset.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			lmask_q <= LMASK_ALL;
		end else if (proc_reset) begin
			lmask_q <= LMASK_ALL;
		end else if (instr_ev.set_mask) begin
			lmask_q <= instr_ev.mask_data;
		end
	end

	// The last running level keeps ruling while the processor waits.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			last_level_q <= 2'h0;
		end else if (!waiting) begin
			last_level_q <= active_level;
		end
	end

	wire [1:0] mask_level = waiting ? last_level_q : active_level;
	wire       eff_summ   = summ_q[mask_level];

	// Summary mask, one per level status register.
	genvar lv;
	generate
		for (lv = 0; lv < NUM_LEVELS; lv++) begin : g_summ
			wire on_lv  = active_level == 2'(lv);
			wire sel_lv = instr_ev.set_level_block_instr && instr_ev.set_level_block_instr_level == 2'(lv);
			wire s_clr  = (on_lv && (instr_ev.supervisor_call_instr || instr_ev.class_taken ||
				(instr_ev.dis && instr_ev.word[WB_SUMM]))) ||
				(sel_lv && !instr_ev.set_level_block_instr_summ);
			wire s_set  = (on_lv && instr_ev.en &&
				instr_ev.word[WB_SUMM]) || (sel_lv && instr_ev.set_level_block_instr_summ) ||
				prio_grant_q[lv] || proc_reset;
			always_ff @(posedge clock or posedge reset) begin
				if (reset) begin
					summ_q[lv] <= 1'b1;
				end else if (s_set) begin
					summ_q[lv] <= 1'b1;
				end else if (s_clr) begin
					summ_q[lv] <= 1'b0;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Three masks must all agree; level 0 has highest priority.
	wire [3:0] allowed = dev_req & dev_mask & lmask_q &
		{NUM_LEVELS{eff_summ}};
	wire [3:0] grant_d = allowed & (~allowed + 4'h1);

	// Class requests follow the recorded bits; warning is masked.
	wire mc_d  = |(psw_q & MC_MASK);
	wire pc_d  = |(psw_q & PC_MASK) ||
		(psw_q[BIT_INVF] && !inv_soft_q);
	wire se_d  = |(psw_q & SE_MASK) ||
		(psw_q[BIT_INVF] && inv_soft_q);
	wire pw_d  = psw_q[BIT_POWER] && eff_summ;
	wire chr_d = set_bits[BIT_CTRL] || set_bits[BIT_IOCHK];

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			machine_check_q <= 1'b0;
			program_check_q <= 1'b0;
			soft_trap_q     <= 1'b0;
			power_int_q     <= 1'b0;
			prio_grant_q    <= 4'h0;
			chan_reset_q    <= 1'b0;
		end else begin
			machine_check_q <= mc_d;
			program_check_q <= pc_d;
			soft_trap_q     <= se_d;
			power_int_q     <= pw_d;
			prio_grant_q    <= grant_d;
			chan_reset_q    <= chr_d;
		end
	end

	// Copy output shows the word before the clear takes effect.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			status_copy_q       <= SW_RESET;
			status_copy_valid_q <= 1'b0;
			level_mask_copy_q   <= LMASK_ALL;
			summary_q           <= 1'b1;
		end else begin
			if (instr_ev.copy_status) begin
				status_copy_q <= psw_q;
			end
			status_copy_valid_q <= instr_ev.copy_status;
			level_mask_copy_q   <= lmask_q;
			summary_q           <= eff_summ;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks on the block's own behaviour.
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	property p_rsv;
		(psw_q & RSV_MASK) == SW_RESET;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bit set");

	property p_align;
		exec_ev.align_err |=> psw_q[BIT_SPEC] ##1 program_check_q;
	endproperty
	a_align: assert property (p_align) else $error("align lost");

	property p_range;
		exec_ev.range_err |=> psw_q[BIT_RANGE];
	endproperty
	a_range: assert property (p_range) else $error("range lost");

	property p_priv;
		exec_ev.priv_instr && !supervisor |=> psw_q[BIT_PRIV];
	endproperty
	a_priv: assert property (p_priv) else $error("priv lost");

	property p_soft;
		inv_soft && !inv_prog |=> ##1 soft_trap_q;
	endproperty
	a_soft: assert property (p_soft) else $error("no soft trap");

	property p_chan;
		exec_ev.ctrl_fail |=> chan_reset_q && psw_q[BIT_CTRL];
	endproperty
	a_chan: assert property (p_chan) else $error("no chan reset");

	property p_pwmask;
		power_int_q |-> $past(eff_summ);
	endproperty
	a_pwmask: assert property (p_pwmask) else $error("warn unmasked");

	property p_grant;
		|prio_grant_q |-> $past(eff_summ) && |$past(lmask_q);
	endproperty
	a_grant: assert property (p_grant) else $error("bad grant");

	property p_svc;
		instr_ev.supervisor_call_instr && !proc_reset && grant_d == 4'h0 &&
			prio_grant_q == 4'h0 && !waiting |=> !summary_q ##0 1'b1
			or ##1 !summ_q[$past(active_level)];
	endproperty
	a_svc: assert property (p_svc) else $error("summary not cleared");

	property p_lmask;
		proc_reset |=> lmask_q == LMASK_ALL;
	endproperty
	a_lmask: assert property (p_lmask) else $error("mask not ones");

	sequence s_copy;
		instr_ev.copy_status && set_bits == SW_RESET;
	endsequence
	sequence s_cleared;
		status_copy_valid_q && (psw_q & ERR_MASK) == SW_RESET;
	endsequence
	property p_copy;
		s_copy |=> s_cleared;
	endproperty
	a_copy: assert property (p_copy) else $error("copy not cleared");

endmodule // swim_status_unit

// File: pkg/swim_pkg.sv
package swim_pkg;

	// Status word field positions.
	localparam int BIT_SPEC   = 0;
	localparam int BIT_RANGE  = 1;
	localparam int BIT_PRIV   = 2;
	localparam int BIT_PROT   = 3;
	localparam int BIT_INVF   = 4;
	localparam int BIT_FLOAT  = 5;
	localparam int BIT_STACK  = 6;
	localparam int BIT_RSV7   = 7;
	localparam int BIT_PARITY = 8;
	localparam int BIT_RSV9   = 9;
	localparam int BIT_CTRL   = 10;
	localparam int BIT_IOCHK  = 11;
	localparam int BIT_SEQ    = 12;
	localparam int BIT_AUTO   = 13;
	localparam int BIT_XLATE  = 14;
	localparam int BIT_POWER  = 15;

	// Instruction word bits used by enable and disable.
	localparam int WB_XCLR = 12;
	localparam int WB_XLAT = 14;
	localparam int WB_SUMM = 15;

	localparam int          NUM_LEVELS = 4;
	localparam logic [15:0] SW_RESET   = 16'h0000;
	localparam logic [15:0] ERR_MASK   = 16'h8d7f;
	localparam logic [15:0] RSV_MASK   = 16'h0280;
	localparam logic [15:0] MC_MASK    = 16'h0d00;
	localparam logic [15:0] PC_MASK    = 16'h000f;
	localparam logic [15:0] SE_MASK    = 16'h0060;
	localparam logic [3:0]  LMASK_ALL  = 4'hf;

	// Opcodes named in the invalid-function decode.
	localparam logic [4:0] OP_BAD_A = 5'h07;
	localparam logic [4:0] OP_BAD_B = 5'h16;
	localparam logic [4:0] OP_BAD_C = 5'h1b;
	localparam logic [4:0] OP_ABSENT = 5'h04;
	localparam logic [4:0] OP_08    = 5'h08;
	localparam logic [4:0] OP_0B    = 5'h0b;
	localparam logic [4:0] OP_1D    = 5'h1d;

	// Errors reported by execution and storage logic, one-cycle strobes.
	typedef struct packed {
		logic       align_err;
		logic       range_err;
		logic       priv_instr;
		logic       store_ro_seg;
		logic       decode_valid;
		logic [4:0] opcode;
		logic [4:0] func;
		logic       float_err;
		logic       stack_err;
		logic       parity_err;
		logic       ctrl_fail;
		logic       chan_fail;
	} swim_exec_s;

	// Instructions and sequences that steer masks, one-cycle strobes.
	typedef struct packed {
		logic        supervisor_call_instr;
		logic        dis;
		logic        en;
		logic [15:0] word;
		logic        set_level_block_instr;
		logic [1:0]  set_level_block_instr_level;
		logic        set_level_block_instr_summ;
		logic        set_mask;
		logic [3:0]  mask_data;
		logic        copy_status;
		logic        class_taken;
		logic        io_op;
		logic        io_cs_accept;
	} swim_instr_s;

	// Load and reset events from console and host.
	typedef struct packed {
		logic sys_reset;
		logic initial_program_load;
		logic auto_ipl;
		logic load_key;
		logic host_load;
	} swim_load_s;

endpackage

// File: test/swim_chan_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
// Channel stand-in: one interrupting device per level, each holding its
// own mask bit that a prepare command loads.
module swim_chan_model (
	// Clock and reset.
	input  wire logic       clock,
	input  wire logic       reset,
	// Prepare command and wanted requests.
	input  wire logic       prep,
	input  wire logic [3:0] prep_bits,
	input  wire logic [3:0] want,
	// Channel reset from the unit.
	input  wire logic       chan_reset_q,
	// Requests and masks seen by the unit.
	output logic      [3:0] dev_req,
	output logic      [3:0] dev_mask
);
	logic [3:0] mask_q;

	// A channel reset drops every mask, as a halt of the channel would.
	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			mask_q <= 4'h0;
		else if (chan_reset_q)
			mask_q <= 4'h0;
		else if (prep)
			mask_q <= prep_bits;
	end

	// A device whose mask is clear never asks, whatever it wants.
	assign dev_req  = want & mask_q;
	assign dev_mask = mask_q;
endmodule // swim_chan_model

// File: test/test_status_word_and_interrupt_masks.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
module test_status_word_and_interrupt_masks
	import swim_pkg::*;
;
	logic        clock, reset, auto_mode, supervisor, waiting, pin, prep;
	logic [1:0]  active_level;
	logic [3:0]  want, prep_bits, dev_req, dev_mask, grant, lmask;
	logic [15:0] copy;
	logic        mc, pc, st, pw, chr, cv, summ;
	swim_exec_s  ev;
	swim_instr_s ir;
	swim_load_s  ld;
	int          fail_count = 0;
	int          n_compared = 0;

	swim_status_unit swim_status_unit_inst (
		.clock(clock), .reset(reset), .exec_ev(ev), .instr_ev(ir),
		.load_ev(ld), .auto_mode(auto_mode), .supervisor(supervisor),
		.active_level(active_level), .waiting(waiting),
		.power_warn_pin(pin), .dev_req(dev_req), .dev_mask(dev_mask),
		.machine_check_q(mc), .program_check_q(pc), .soft_trap_q(st),
		.power_int_q(pw), .prio_grant_q(grant), .chan_reset_q(chr),
		.status_copy_q(copy), .status_copy_valid_q(cv),
		.level_mask_copy_q(lmask), .summary_q(summ)
	);
	swim_chan_model swim_chan_model_inst (
		.clock(clock), .reset(reset), .prep(prep), .prep_bits(prep_bits),
		.want(want), .chan_reset_q(chr), .dev_req(dev_req),
		.dev_mask(dev_mask)
	);

	// 10 MHz clock.
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////////////
	// Inputs move on falling edges only, so no sampling race is possible.
	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask

	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	// Strobes last one cycle; the second edge lets registered outputs land.
	task automatic fire();
		tick(1);
		ev = '0;
		ir = '0;
		ld = '0;
		tick(1);
	endtask

	task automatic enable(input logic [15:0] w);
		ir.en = 1'b1;
		ir.word = w;
		fire();
	endtask

	// The valid pulse stands one cycle, so it is looked at right away.
	task automatic copy_word(input logic [15:0] w);
		ir.copy_status = 1'b1;
		tick(1);
		ir = '0;
		check("copy valid", 16'h0001, 16'(cv));
		check("status word", w, copy);
		tick(1);
	endtask

	// Class outputs are {machine, program, soft}.
	task automatic err(input swim_exec_s e, input logic [15:0] w,
		input logic [2:0] cls);
		ev = e;
		tick(1);
		ev = '0;
		check("channel reset", 16'(w[10] | w[11]), 16'(chr));
		tick(1);
		check("class outputs", 16'(cls), 16'({mc, pc, st}));
		copy_word(w);
		check("class after copy", 16'h0000, 16'({mc, pc, st}));
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		check("level mask", 16'(LMASK_ALL), 16'(lmask));
		check("summary", 16'h0001, 16'(summ));
		copy_word(SW_RESET);
		$display("reset test done");
	endtask

	// Exec vector bits: 19 align, 18 range, 17 priv, 16 read-only store,
	// 15 decode valid, 14:10 opcode, 9:5 function, 4 float, 3 stack,
	// 2 parity, 1 control, 0 channel.
	task automatic t_errors();
		err(20'h80000, 16'h0001, 3'b010);
		err(20'h40000, 16'h0002, 3'b010);
		err(20'h20000, 16'h0004, 3'b010);
		err(20'h09c00, 16'h0010, 3'b010);
		err(20'h0d800, 16'h0010, 3'b010);
		err(20'h0ec00, 16'h0010, 3'b010);
		err(20'h0aca0, 16'h0010, 3'b010);
		err(20'h0a020, 16'h0010, 3'b010);
		err(20'h0a080, 16'h0000, 3'b000);
		err(20'h0f580, 16'h0010, 3'b010);
		err(20'h09000, 16'h0010, 3'b001);
		supervisor = 1'b1;
		err(20'h0ac60, 16'h0010, 3'b001);
		err(20'h20000, 16'h0000, 3'b000);
		supervisor = 1'b0;
		err(20'h00010, 16'h0020, 3'b001);
		err(20'h00008, 16'h0040, 3'b001);
		err(20'h00004, 16'h0100, 3'b100);
		err(20'h00002, 16'h0400, 3'b100);
		err(20'h00001, 16'h0800, 3'b100);
		$display("error test done");
	endtask

	// A read-only store only counts once the translator is on.
	task automatic t_flags();
		err(20'h10000, 16'h0000, 3'b000);
		enable(16'h4000);
		err(20'h10000, 16'h4008, 3'b010);
		ir.dis = 1'b1;
		ir.word = 16'h4000;
		fire();
		copy_word(16'h0000);
		enable(16'h5000);
		copy_word(16'h0000);
		ir.io_cs_accept = 1'b1;
		fire();
		copy_word(16'h1000);
		ir.io_op = 1'b1;
		fire();
		copy_word(16'h0000);
		ld.auto_ipl = 1'b1;
		fire();
		copy_word(16'h2000);
		ld.host_load = 1'b1;
		fire();
		copy_word(16'h0000);
		ld.auto_ipl = 1'b1;
		fire();
		ld.load_key = 1'b1;
		fire();
		copy_word(16'h0000);
		ld.auto_ipl = 1'b1;
		fire();
		ld.initial_program_load = 1'b1;
		fire();
		copy_word(16'h0000);
		$display("flag test done");
	endtask

	task automatic prepare(input logic [3:0] bits);
		prep = 1'b1;
		prep_bits = bits;
		tick(1);
		prep = 1'b0;
		tick(2);
	endtask

	task automatic t_grant();
		want = 4'h4;
		prepare(4'hf);
		check("grant", 16'h0004, 16'(grant));
		ir.set_mask = 1'b1;
		ir.mask_data = 4'hb;
		fire();
		check("level mask copy", 16'h000b, 16'(lmask));
		check("grant", 16'h0000, 16'(grant));
		ld.sys_reset = 1'b1;
		fire();
		check("level mask copy", 16'h000f, 16'(lmask));
		ir.supervisor_call_instr = 1'b1;
		fire();
		check("summary", 16'h0000, 16'(summ));
		check("grant", 16'h0000, 16'(grant));
		enable(16'h8000);
		check("grant", 16'h0004, 16'(grant));
		prepare(4'hb);
		check("grant", 16'h0000, 16'(grant));
		ir.class_taken = 1'b1;
		fire();
		check("summary", 16'h0000, 16'(summ));
		enable(16'h8000);
		check("summary", 16'h0001, 16'(summ));
		ir.dis = 1'b1;
		ir.word = 16'h8000;
		fire();
		check("summary", 16'h0000, 16'(summ));
		enable(16'h8000);
		active_level = 2'd1;
		ir.set_level_block_instr = 1'b1;
		ir.set_level_block_instr_level = 2'd1;
		fire();
		active_level = 2'd0;
		waiting = 1'b1;
		tick(2);
		check("summary", 16'h0000, 16'(summ));
		waiting = 1'b0;
		tick(2);
		check("summary", 16'h0001, 16'(summ));
		ir.set_level_block_instr = 1'b1;
		ir.set_level_block_instr_level = 2'd1;
		ir.set_level_block_instr_summ = 1'b1;
		fire();
		active_level = 2'd1;
		tick(2);
		check("summary", 16'h0001, 16'(summ));
		active_level = 2'd0;
		$display("grant test done");
	endtask

	// The pin passes a three-flop synchroniser, hence the longer waits.
	task automatic t_power();
		ir.supervisor_call_instr = 1'b1;
		fire();
		pin = 1'b1;
		tick(8);
		check("power interrupt", 16'h0000, 16'(pw));
		copy_word(16'h8000);
		enable(16'h8000);
		tick(1);
		check("power interrupt", 16'h0001, 16'(pw));
		pin = 1'b0;
		tick(4);
		copy_word(16'h8000);
		copy_word(16'h0000);
		check("power interrupt", 16'h0000, 16'(pw));
		$display("power test done");
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// The tests need well under a thousand cycles; ten thousand is a hang.
	initial begin
		#1000000;
		fail_count++;
		print_verdict();
	end

	// Main sequence.
	initial begin
		reset = 1'b1;
		ev = '0;
		ir = '0;
		ld = '0;
		auto_mode = 1'b0;
		supervisor = 1'b0;
		active_level = 2'd0;
		waiting = 1'b0;
		pin = 1'b0;
		prep = 1'b0;
		prep_bits = 4'h0;
		want = 4'h0;
		repeat (5) @(negedge clock);
		reset = 1'b0;
		t_reset();
		t_errors();
		t_flags();
		t_grant();
		t_power();
		print_verdict();
	end
endmodule // test_status_word_and_interrupt_masks
